// *** hdl/converter_cfg_pkg.sv ***
/*
 Shared constants and types of the converter configuration bank: register
 addresses, field positions, writable masks, reset values, reference codes
 and the serial frame layout. Assumes a single 10 MHz system clock.
*/
`default_nettype none
package converter_cfg_pkg;
    typedef logic [6:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;
    typedef logic [1:0] ref_code_t;

    // Register addresses
    localparam reg_addr_t SLEEP_CTRL_ADDR = 7'h08;
    localparam reg_addr_t OUT_BUF_POWER_ADDR = 7'h09;
    localparam reg_addr_t SLEEP_MASK_ADDR = 7'h0d;
    localparam reg_addr_t SYNC_REF_CLK_ADDR = 7'h0e;
    localparam reg_addr_t ANALOG_INPUT_ADDR = 7'h11;

    // Reset values
    localparam reg_data_t SLEEP_CTRL_RESET = 8'h00;
    localparam reg_data_t OUT_BUF_POWER_RESET = 8'h00;
    localparam reg_data_t SLEEP_MASK_RESET = 8'h00;
    localparam reg_data_t SYNC_REF_CLK_RESET = 8'h00;
    localparam reg_data_t ANALOG_INPUT_RESET = 8'h00;

    // Writable bits; reserved bits read back as zero
    localparam reg_data_t SLEEP_CTRL_WMASK = 8'h01;
    localparam reg_data_t OUT_BUF_POWER_WMASK = 8'h3f;
    localparam reg_data_t SLEEP_MASK_WMASK = 8'h0e;
    localparam reg_data_t SYNC_REF_CLK_WMASK = 8'hef;
    localparam reg_data_t ANALOG_INPUT_WMASK = 8'h30;

    // Sleep control field
    localparam int unsigned GLOBAL_SLEEP_BIT = 0;

    // Output buffer power fields
    localparam int unsigned FRAME_CLK_OFF_BIT = 5;
    localparam int unsigned BIT_CLK_OFF_BIT = 4;
    localparam int unsigned CHAN_A_LANE1_OFF_BIT = 3;
    localparam int unsigned CHAN_A_LANE0_OFF_BIT = 2;
    localparam int unsigned CHAN_B_LANE1_OFF_BIT = 1;
    localparam int unsigned CHAN_B_LANE0_OFF_BIT = 0;

    // Global sleep mask fields
    localparam int unsigned KEEP_SAMPLE_CLK_BIT = 3;
    localparam int unsigned KEEP_REF_AMP_BIT = 2;
    localparam int unsigned BANDGAP_OFF_BIT = 1;

    // Sync, reference and clock select fields
    localparam int unsigned PIN_IS_SYNC_BIT = 7;
    localparam int unsigned SW_SYNC_BIT = 6;
    localparam int unsigned SW_SYNC_EN_BIT = 5;
    localparam int unsigned REF_BY_REG_BIT = 3;
    localparam int unsigned REF_SEL_HI_BIT = 2;
    localparam int unsigned REF_SEL_LO_BIT = 1;
    localparam int unsigned SE_CLK_BIT = 0;

    // Analog input fields
    localparam int unsigned CHAN_A_SE_BIT = 5;
    localparam int unsigned CHAN_B_SE_BIT = 4;

    // Reference source codes
    localparam ref_code_t REF_INTERNAL = 2'h0;
    localparam ref_code_t REF_EXT_BUFFERED = 2'h1;
    localparam ref_code_t REF_EXT_DIRECT = 2'h2;

    // Serial frame: read flag, 7 address bits, 8 data bits, MSB first
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] HEADER_BITS = 5'h08;
endpackage : converter_cfg_pkg
`default_nettype wire

// *** hdl/spi_reg_if.sv ***
/*
 Register access carrier between the serial slave and the register bank.
 Assumes both ends run on the same clock; rdata is combinational from addr.
*/
`default_nettype none
interface spi_reg_if;
    import converter_cfg_pkg::*;
    reg_addr_t addr;
    reg_data_t wdata;
    logic wr_en;
    reg_data_t rdata;

    modport serial_side (output addr, output wdata, output wr_en, input rdata);
    modport bank_side (input addr, input wdata, input wr_en, output rdata);
endinterface : spi_reg_if
`default_nettype wire

// *** hdl/two_flop_sync.sv ***
/*
 Two-flop synchroniser for a group of asynchronous pin levels.
 Assumes each bit is a slow level; no multi-bit coherence is promised.
*/
`default_nettype none
module two_flop_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb begin
        state_next.first = async_in;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;
endmodule : two_flop_sync
`default_nettype wire

// *** hdl/spi_frame_slave.sv ***
/*
 Serial register port: 16-bit frames, select low, data taken on clock rise,
 read data launched on clock fall. Assumes the serial clock runs at most at
 a tenth of clk, since pins are oversampled after two flops.
*/
`default_nettype none
module spi_frame_slave
    import converter_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic spi_sen_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    spi_reg_if.serial_side bus
);
    typedef struct packed {
        logic sclk_prev;
        logic [4:0] count;
        reg_data_t shift_in;
        reg_data_t shift_out;
        logic is_read;
        logic load_pending;
        reg_addr_t addr;
        reg_data_t wdata;
        logic wr_en;
        logic sdo;
        logic sdo_oe;
    } slave_state_t;

    slave_state_t state_reg;
    slave_state_t state_next;
    logic [2:0] pins_s;
    logic sen_n_s;
    logic sclk_s;
    logic sdi_s;
    reg_data_t shifted;

    two_flop_sync #(.WIDTH(3)) pin_sync (
        .clk(clk),
        .reset(reset),
        .async_in({spi_sen_n, spi_sclk, spi_sdi}),
        .sync_out(pins_s)
    );

    assign sen_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s = pins_s[0];

    always_comb begin
        shifted = {state_reg.shift_in[6:0], sdi_s};
        state_next = state_reg;
        state_next.sclk_prev = sclk_s;
        state_next.wr_en = 1'b0;
        state_next.load_pending = 1'b0;
        if (state_reg.load_pending) begin
            state_next.shift_out = bus.rdata;
        end
        if (sen_n_s) begin
            // Deselect aborts a partial frame; no write is issued
            state_next.count = '0;
            state_next.sdo_oe = 1'b0;
        end else if (sclk_s && !state_reg.sclk_prev && state_reg.count < FRAME_BITS) begin
            state_next.shift_in = shifted;
            state_next.count = state_reg.count + 5'h01;
            if (state_reg.count == HEADER_BITS - 5'h01) begin
                state_next.is_read = shifted[7];
                state_next.addr = shifted[6:0];
                state_next.load_pending = shifted[7];
                state_next.sdo_oe = shifted[7];
            end
            if (state_reg.count == FRAME_BITS - 5'h01) begin
                state_next.wdata = shifted;
                state_next.wr_en = !state_reg.is_read;
            end
        end else if (!sclk_s && state_reg.sclk_prev && state_reg.sdo_oe) begin
            state_next.sdo = state_reg.shift_out[7];
            state_next.shift_out = {state_reg.shift_out[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus.addr = state_reg.addr;
    assign bus.wdata = state_reg.wdata;
    assign bus.wr_en = state_reg.wr_en;
    assign spi_sdo = state_reg.sdo;
    assign spi_sdo_oe = state_reg.sdo_oe;
endmodule : spi_frame_slave
`default_nettype wire

// *** hdl/converter_power_sync_config_regs.sv ***
/*
 Power, sync, reference and clock-style configuration bank of a dual-channel
 converter, reached over the serial register port. Assumes the host keeps
 the serial clock slow against clk and writes reserved bits as zero.
*/
// Behaviour
// - Output power bit 5 set turns the frame clock driver off.
// - Output power bit 4 set turns the bit clock driver off.
// - Bit 3 turns channel A lane 1 off; never off automatically.
// - Bit 2 set turns channel A lane 0 driver off.
// - Bit 1 turns channel B lane 1 off; never off automatically.
// - Bit 0 turns channel B lane 0 off; never off automatically.
// - Mask bit 3 keeps sample clock buffer on during global sleep.
// - Mask bit 2 keeps reference amplifier on during global sleep.
// - Mask bit 1 set also turns the bandgap off in sleep.
// - Bit 7 picks pin high meaning: 0 sleep, 1 sync.
// - Setting bit 6 with software sync enabled issues sync; host clears it.
// - Bit 5 takes sync from the register instead of the pin.
// - Bit 3 picks reference source, pin or register; clear, the clock stays differential.
// - Reference codes: 00 internal, 01 external buffered, 10 external direct.
// - Register-selected single-ended clock turns the differential buffer off.
// - Analog bits 5 and 4 pick single-ended input for A, B.
// - Global sleep bit powers blocks down as the mask selects.
`default_nettype none
module converter_power_sync_config_regs
    import converter_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic spi_sen_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic sync_or_sleep_pin,
    input wire logic reference_buffer_pin,
    output logic frame_clk_driver_off,
    output logic bit_clk_driver_off,
    output logic chan_a_lane1_off,
    output logic chan_a_lane0_off,
    output logic chan_b_lane1_off,
    output logic chan_b_lane0_off,
    output logic chip_sleep,
    output logic sample_clk_buffer_off,
    output logic reference_amp_off,
    output logic bandgap_off,
    output logic single_ended_clk_in,
    output logic use_internal_ref,
    output logic use_ext_ref_buffered,
    output logic use_ext_ref_direct,
    output logic chan_a_single_ended_in,
    output logic chan_b_single_ended_in,
    output logic sync_pulse
);
    typedef struct packed {
        reg_data_t sleep_ctrl;
        reg_data_t out_buf;
        reg_data_t mask;
        reg_data_t sync_ref;
        reg_data_t analog;
        logic pin_prev;
        logic frame_off;
        logic bit_off;
        logic a1_off;
        logic a0_off;
        logic b1_off;
        logic b0_off;
        logic sleep;
        logic clkbuf_off;
        logic refamp_off;
        logic bg_off;
        logic se_clk;
        logic int_ref;
        logic ext_buf_ref;
        logic ext_direct_ref;
        logic a_se;
        logic b_se;
        logic sync;
    } bank_state_t;

    bank_state_t state_reg;
    bank_state_t state_next;
    spi_reg_if bus ();
    logic [1:0] pins_s;
    logic sync_pin_s;
    logic reference_buffer_pin_pin_s;
    ref_code_t ref_code;
    logic by_reg;
    logic pin_edge;

    spi_frame_slave serial (
        .clk(clk),
        .reset(reset),
        .spi_sen_n(spi_sen_n),
        .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe),
        .bus(bus.serial_side)
    );

    two_flop_sync #(.WIDTH(2)) pin_sync (
        .clk(clk),
        .reset(reset),
        .async_in({sync_or_sleep_pin, reference_buffer_pin}),
        .sync_out(pins_s)
    );

    assign sync_pin_s = pins_s[1];
    assign reference_buffer_pin_pin_s = pins_s[0];

    // Unmapped addresses read as zero
    always_comb begin
        unique case (bus.addr)
            SLEEP_CTRL_ADDR: bus.rdata = state_reg.sleep_ctrl;
            OUT_BUF_POWER_ADDR: bus.rdata = state_reg.out_buf;
            SLEEP_MASK_ADDR: bus.rdata = state_reg.mask;
            SYNC_REF_CLK_ADDR: bus.rdata = state_reg.sync_ref;
            ANALOG_INPUT_ADDR: bus.rdata = state_reg.analog;
            default: bus.rdata = 8'h00;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        ref_code = REF_INTERNAL;
        if (bus.wr_en) begin
            unique case (bus.addr)
                SLEEP_CTRL_ADDR: state_next.sleep_ctrl = bus.wdata & SLEEP_CTRL_WMASK;
                OUT_BUF_POWER_ADDR: state_next.out_buf = bus.wdata & OUT_BUF_POWER_WMASK;
                SLEEP_MASK_ADDR: state_next.mask = bus.wdata & SLEEP_MASK_WMASK;
                SYNC_REF_CLK_ADDR: state_next.sync_ref = bus.wdata & SYNC_REF_CLK_WMASK;
                ANALOG_INPUT_ADDR: state_next.analog = bus.wdata & ANALOG_INPUT_WMASK;
                default: state_next.sleep_ctrl = state_reg.sleep_ctrl;
            endcase
        end
        state_next.pin_prev = sync_pin_s;
        pin_edge = sync_pin_s && !state_reg.pin_prev;

        state_next.frame_off = state_next.out_buf[FRAME_CLK_OFF_BIT];
        state_next.bit_off = state_next.out_buf[BIT_CLK_OFF_BIT];
        // Lanes follow their bits alone, never the lane mode
        state_next.a1_off = state_next.out_buf[CHAN_A_LANE1_OFF_BIT];
        state_next.b1_off = state_next.out_buf[CHAN_B_LANE1_OFF_BIT];
        state_next.b0_off = state_next.out_buf[CHAN_B_LANE0_OFF_BIT];
        state_next.a0_off = state_next.out_buf[CHAN_A_LANE0_OFF_BIT];

        // Sleep from register bit or pin in sleep role
        state_next.sleep = state_next.sleep_ctrl[GLOBAL_SLEEP_BIT]
            || (sync_pin_s && !state_next.sync_ref[PIN_IS_SYNC_BIT]);

        // Register or pin chooses reference; only the register sets clock style
        by_reg = state_next.sync_ref[REF_BY_REG_BIT];
        // Single-ended clock only under register control
        state_next.se_clk = by_reg && state_next.sync_ref[SE_CLK_BIT];
        // Clock buffer mask; single-ended clock also idles it
        state_next.clkbuf_off = (state_next.sleep && !state_next.mask[KEEP_SAMPLE_CLK_BIT])
            || state_next.se_clk;
        state_next.refamp_off = state_next.sleep && !state_next.mask[KEEP_REF_AMP_BIT];
        // Bandgap off only when asked, slower wake-up is the price
        state_next.bg_off = state_next.sleep && state_next.mask[BANDGAP_OFF_BIT];

        // Reference decode; unused code falls back to internal
        if (by_reg) begin
            ref_code = state_next.sync_ref[REF_SEL_HI_BIT:REF_SEL_LO_BIT];
        end else if (reference_buffer_pin_pin_s) begin
            ref_code = REF_EXT_BUFFERED;
        end
        state_next.ext_buf_ref = (ref_code == REF_EXT_BUFFERED);
        state_next.ext_direct_ref = (ref_code == REF_EXT_DIRECT);
        state_next.int_ref = !state_next.ext_buf_ref && !state_next.ext_direct_ref;

        state_next.a_se = state_next.analog[CHAN_A_SE_BIT];
        state_next.b_se = state_next.analog[CHAN_B_SE_BIT];

        // Sync from rising register bit, else pin edge
        if (state_next.sync_ref[SW_SYNC_EN_BIT]) begin
            state_next.sync = state_next.sync_ref[SW_SYNC_BIT]
                && !state_reg.sync_ref[SW_SYNC_BIT];
        end else begin
            state_next.sync = pin_edge && state_next.sync_ref[PIN_IS_SYNC_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.sleep_ctrl <= SLEEP_CTRL_RESET;
            state_reg.out_buf <= OUT_BUF_POWER_RESET;
            state_reg.mask <= SLEEP_MASK_RESET;
            state_reg.sync_ref <= SYNC_REF_CLK_RESET;
            state_reg.analog <= ANALOG_INPUT_RESET;
            state_reg.int_ref <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign frame_clk_driver_off = state_reg.frame_off;
    assign bit_clk_driver_off = state_reg.bit_off;
    assign chan_a_lane1_off = state_reg.a1_off;
    assign chan_a_lane0_off = state_reg.a0_off;
    assign chan_b_lane1_off = state_reg.b1_off;
    assign chan_b_lane0_off = state_reg.b0_off;
    assign chip_sleep = state_reg.sleep;
    assign sample_clk_buffer_off = state_reg.clkbuf_off;
    assign reference_amp_off = state_reg.refamp_off;
    assign bandgap_off = state_reg.bg_off;
    assign single_ended_clk_in = state_reg.se_clk;
    assign use_internal_ref = state_reg.int_ref;
    assign use_ext_ref_buffered = state_reg.ext_buf_ref;
    assign use_ext_ref_direct = state_reg.ext_direct_ref;
    assign chan_a_single_ended_in = state_reg.a_se;
    assign chan_b_single_ended_in = state_reg.b_se;
    assign sync_pulse = state_reg.sync;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    frame_clk_write_a: assert property (
        bus.wr_en && bus.addr == OUT_BUF_POWER_ADDR
        |=> frame_clk_driver_off == $past(bus.wdata[FRAME_CLK_OFF_BIT]))
        else $error("frame clock driver power does not follow write");
    bit_clk_write_a: assert property (
        bus.wr_en && bus.addr == OUT_BUF_POWER_ADDR
        |=> bit_clk_driver_off == $past(bus.wdata[BIT_CLK_OFF_BIT]))
        else $error("bit clock driver power does not follow write");
    lane_a1_hold_a: assert property (
        !(bus.wr_en && bus.addr == OUT_BUF_POWER_ADDR) |=> $stable(chan_a_lane1_off))
        else $error("channel A lane 1 power changed without a write");
    lane_a0_write_a: assert property (
        bus.wr_en && bus.addr == OUT_BUF_POWER_ADDR
        |=> chan_a_lane0_off == $past(bus.wdata[CHAN_A_LANE0_OFF_BIT]))
        else $error("channel A lane 0 power does not follow write");
    lane_b1_hold_a: assert property (
        !(bus.wr_en && bus.addr == OUT_BUF_POWER_ADDR) |=> $stable(chan_b_lane1_off))
        else $error("channel B lane 1 power changed without a write");
    lane_b0_write_a: assert property (
        bus.wr_en && bus.addr == OUT_BUF_POWER_ADDR
        |=> chan_b_lane0_off == $past(bus.wdata[CHAN_B_LANE0_OFF_BIT]))
        else $error("channel B lane 0 power does not follow write");
    clk_buf_mask_a: assert property (
        chip_sleep && !single_ended_clk_in
        |-> sample_clk_buffer_off == !state_reg.mask[KEEP_SAMPLE_CLK_BIT])
        else $error("sample clock buffer ignores its sleep mask");
    ref_amp_mask_a: assert property (
        reference_amp_off == (chip_sleep && !state_reg.mask[KEEP_REF_AMP_BIT]))
        else $error("reference amplifier ignores its sleep mask");
    bandgap_mask_a: assert property (
        bandgap_off |-> chip_sleep && state_reg.mask[BANDGAP_OFF_BIT])
        else $error("bandgap off outside masked sleep");
    pin_sleep_role_a: assert property (
        sync_pin_s && !state_reg.sync_ref[PIN_IS_SYNC_BIT] && !bus.wr_en |=> chip_sleep)
        else $error("pin high in sleep role did not sleep");
    sw_sync_pulse_a: assert property (
        $rose(state_reg.sync_ref[SW_SYNC_BIT]) && state_reg.sync_ref[SW_SYNC_EN_BIT]
        |-> sync_pulse ##1 !sync_pulse)
        else $error("software sync did not give one pulse");
    pin_sync_blocked_a: assert property (
        state_reg.sync_ref[SW_SYNC_EN_BIT] && !$rose(state_reg.sync_ref[SW_SYNC_BIT])
        |-> !sync_pulse)
        else $error("sync pulse while register sync owns sync");
    clk_style_source_a: assert property (
        !state_reg.sync_ref[REF_BY_REG_BIT] |-> !single_ended_clk_in)
        else $error("single-ended clock without register control");
    ref_decode_a: assert property (
        state_reg.sync_ref[REF_BY_REG_BIT]
        && state_reg.sync_ref[REF_SEL_HI_BIT:REF_SEL_LO_BIT] == REF_EXT_DIRECT
        |-> use_ext_ref_direct && !use_ext_ref_buffered && !use_internal_ref)
        else $error("reference decode wrong for direct external");
    se_clk_buffer_a: assert property (
        single_ended_clk_in |-> sample_clk_buffer_off)
        else $error("differential buffer on with single-ended clock");
    analog_style_a: assert property (
        bus.wr_en && bus.addr == ANALOG_INPUT_ADDR
        |=> chan_a_single_ended_in == $past(bus.wdata[CHAN_A_SE_BIT])
        && chan_b_single_ended_in == $past(bus.wdata[CHAN_B_SE_BIT]))
        else $error("analog input style does not follow write");
    global_sleep_a: assert property (
        bus.wr_en && bus.addr == SLEEP_CTRL_ADDR && bus.wdata[GLOBAL_SLEEP_BIT]
        |=> chip_sleep)
        else $error("global sleep bit did not sleep");
endmodule : converter_power_sync_config_regs
`default_nettype wire

// *** tb/converter_power_sync_config_regs_test.sv ***
/*
 Self-checking bench of the converter configuration bank.
 Assumes the serial frame contract of the bank and a 10 MHz clk.
*/
`default_nettype none
module converter_power_sync_config_regs_test
    import converter_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset, spi_sen_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
    logic sync_or_sleep_pin, reference_buffer_pin;
    logic [16:0] o;
    logic [15:0] seed;
    reg_data_t m [0:127];
    int err_count, total_checks, pulses, p0;
    reg_addr_t adr [0:5] = '{SLEEP_CTRL_ADDR, OUT_BUF_POWER_ADDR, SLEEP_MASK_ADDR,
        SYNC_REF_CLK_ADDR, ANALOG_INPUT_ADDR, 7'h12};

    converter_power_sync_config_regs u_dut (.clk(clk), .reset(reset),
        .spi_sen_n(spi_sen_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .sync_or_sleep_pin(sync_or_sleep_pin),
        .reference_buffer_pin(reference_buffer_pin), .frame_clk_driver_off(o[16]),
        .bit_clk_driver_off(o[15]), .chan_a_lane1_off(o[14]), .chan_a_lane0_off(o[13]),
        .chan_b_lane1_off(o[12]), .chan_b_lane0_off(o[11]), .chip_sleep(o[10]),
        .sample_clk_buffer_off(o[9]), .reference_amp_off(o[8]), .bandgap_off(o[7]),
        .single_ended_clk_in(o[6]), .use_internal_ref(o[5]), .use_ext_ref_buffered(o[4]),
        .use_ext_ref_direct(o[3]), .chan_a_single_ended_in(o[2]),
        .chan_b_single_ended_in(o[1]), .sync_pulse(o[0]));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (o[0] === 1'b1) pulses <= pulses + 1;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic reg_data_t wm(input reg_addr_t a);
        case (a)
            SLEEP_CTRL_ADDR: return SLEEP_CTRL_WMASK;
            OUT_BUF_POWER_ADDR: return OUT_BUF_POWER_WMASK;
            SLEEP_MASK_ADDR: return SLEEP_MASK_WMASK;
            SYNC_REF_CLK_ADDR: return SYNC_REF_CLK_WMASK;
            ANALOG_INPUT_ADDR: return ANALOG_INPUT_WMASK;
            default: return 8'h00;
        endcase
    endfunction : wm

    // Pin control reads as buffered when high; code 11 reads as internal
    function automatic logic [15:0] expv();
        logic s;
        logic [1:0] c;
        reg_data_t e;
        reg_data_t k;
        e = m[SYNC_REF_CLK_ADDR];
        k = m[SLEEP_MASK_ADDR];
        s = m[SLEEP_CTRL_ADDR][0] | (sync_or_sleep_pin & ~e[7]);
        c = e[3] ? e[2:1] : {1'b0, reference_buffer_pin};
        return {m[OUT_BUF_POWER_ADDR][5:0], s, (s & ~k[3]) | (e[3] & e[0]), s & ~k[2],
            s & k[1], e[3] & e[0], c == REF_INTERNAL || c == 2'h3, c == REF_EXT_BUFFERED,
            c == REF_EXT_DIRECT, m[ANALOG_INPUT_ADDR][5:4]};
    endfunction : expv

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk

    task automatic spi(input logic rd, input reg_addr_t a, input reg_data_t d,
            output reg_data_t q);
        logic [15:0] f;
        f = {rd, a, d};
        q = 8'h00;
        spi_sen_n = 1'b0;
        repeat (5) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            spi_sdi = f[i];
            repeat (5) @(negedge clk);
            if (rd && i < 8) begin
                q[i] = spi_sdo;
                chk("sdo_oe", 16'h1, {15'h0, spi_sdo_oe});
            end
            spi_sclk = 1'b1;
            repeat (5) @(negedge clk);
            spi_sclk = 1'b0;
        end
        spi_sen_n = 1'b1;
        repeat (8) @(negedge clk);
        if (!rd) m[a] = d & wm(a);
    endtask : spi

    task automatic wr(input reg_addr_t a, input reg_data_t d);
        reg_data_t q;
        spi(1'b0, a, d, q);
    endtask : wr

    task automatic rchk(input reg_addr_t a);
        reg_data_t q;
        spi(1'b1, a, 8'h00, q);
        chk("readback", {8'h00, m[a]}, {8'h00, q});
    endtask : rchk

    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    // Long enough for about ninety frames plus margin
    initial begin
        repeat (50000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        {spi_sen_n, spi_sclk, spi_sdi, sync_or_sleep_pin, reference_buffer_pin} = 5'h10;
        reset = 1'b1;
        pulses = 0;
        err_count = 0;
        total_checks = 0;
        seed = 16'hf9e5;
        foreach (m[i]) m[i] = 8'h00;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        chk("reset outputs", expv(), o[16:1]);
        foreach (adr[i]) rchk(adr[i]);
        repeat (30) begin
            seed = lfsr(seed);
            sync_or_sleep_pin = seed[12];
            reference_buffer_pin = seed[13];
            wr(adr[int'(seed[10:8]) % 6], seed[7:0]);
            rchk(adr[int'(seed[10:8]) % 6]);
            chk("outputs", expv(), o[16:1]);
        end
        sync_or_sleep_pin = 1'b0;
        for (int c = 0; c < 4; c++) begin
            wr(SYNC_REF_CLK_ADDR, {4'h0, 1'b1, 2'(c), c[0]});
            chk("ref select", expv(), o[16:1]);
        end
        wr(SLEEP_CTRL_ADDR, 8'h01);
        for (int k = 0; k < 8; k++) begin
            wr(SLEEP_MASK_ADDR, 8'(k << 1));
            chk("sleep mask", expv(), o[16:1]);
        end
        wr(SLEEP_CTRL_ADDR, 8'h00);
        wr(SYNC_REF_CLK_ADDR, 8'h00);
        sync_or_sleep_pin = 1'b1;
        repeat (6) @(negedge clk);
        chk("pin sleep", expv(), o[16:1]);
        sync_or_sleep_pin = 1'b0;
        wr(SYNC_REF_CLK_ADDR, 8'h80);
        p0 = pulses;
        sync_or_sleep_pin = 1'b1;
        repeat (8) @(negedge clk);
        chk("pin sync", 16'h1, 16'(pulses - p0));
        chk("no sleep", expv(), o[16:1]);
        sync_or_sleep_pin = 1'b0;
        wr(SYNC_REF_CLK_ADDR, 8'h00);
        p0 = pulses;
        wr(SYNC_REF_CLK_ADDR, 8'h40);
        wr(SYNC_REF_CLK_ADDR, 8'h00);
        wr(SYNC_REF_CLK_ADDR, 8'h60);
        wr(SYNC_REF_CLK_ADDR, 8'h20);
        wr(SYNC_REF_CLK_ADDR, 8'h60);
        wr(SYNC_REF_CLK_ADDR, 8'he0);
        sync_or_sleep_pin = 1'b1;
        repeat (8) @(negedge clk);
        chk("soft sync", 16'h2, 16'(pulses - p0));
        print_verdict();
    end
endmodule : converter_power_sync_config_regs_test
`default_nettype wire
